// ---- inc/ppf_pkg.sv ----
/*
 * Constants for the pin pull and function select block: register
 * offsets, field positions, reset values and selector codes.
 * Assumes a 32-bit register port with byte offsets on an 8-bit address.
 */
package ppf_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_PIN_SLOTS = 19;
    localparam int FN_COUNT      = 7;
    localparam int SEL_W         = 3;
    localparam int ADDR_W        = 8;
    localparam int DATA_W        = 32;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_PULL_ON_STAGE   = 8'h00;
    localparam logic [7:0] REG_PULL_OFF_COMMIT = 8'h04;
    localparam logic [7:0] REG_PULL_EN         = 8'h08;
    localparam logic [7:0] REG_POL_UP_STAGE    = 8'h0c;
    localparam logic [7:0] REG_POL_DN_COMMIT   = 8'h10;
    localparam logic [7:0] REG_POL             = 8'h14;
    localparam logic [7:0] REG_FUNC_WRITE      = 8'h18;
    localparam logic [7:0] REG_FUNC_PIN        = 8'h1c;
    localparam logic [7:0] REG_FUNC_READ       = 8'h20;

    // ----------------------------------------------------------------
    // Fields of the function write word
    // ----------------------------------------------------------------
    localparam int FW_PIN_LSB = 0;
    localparam int FW_PIN_W   = 5;
    localparam int FW_SEL_LSB = 8;

    // ----------------------------------------------------------------
    // Pin map and reset values
    // ----------------------------------------------------------------
    localparam logic [18:0] PIN_MASK      = 19'h6ffff;
    localparam logic [18:0] PULL_EN_RST   = 19'h6ffff;
    localparam logic [18:0] PULL_POL_RST  = 19'h68e77;
    localparam logic [18:0] XTAL_PIN_MASK = 19'h00100;
    localparam int          XTAL_PIN      = 8;
    localparam logic [2:0]  SEL_GPIO      = 3'h0;
    localparam logic [2:0]  SEL_XTAL      = 3'h7;
    localparam logic [2:0]  SEL_RST       = 3'h0;
    localparam logic [31:0] RD_BAD_PIN    = 32'hffff_ffff;

endpackage

// ---- verilog/ppf_pin_mux.sv ----
/*
 * One pad's function multiplexer: steers general I/O or one of seven
 * peripheral functions onto the pad, and the pad level back to them.
 * Assumes pad and peripheral signals are synchronous to clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none

module ppf_pin_mux (
    input  wire logic                          clk_sys,
    input  wire logic                          sys_rst,
    input  wire logic                          ce,
    input  wire logic [ppf_pkg::SEL_W-1:0]    sel,
    input  wire logic                          gpio_out,
    input  wire logic                          gpio_oe,
    input  wire logic [ppf_pkg::FN_COUNT-1:0] fn_out,
    input  wire logic [ppf_pkg::FN_COUNT-1:0] fn_oe,
    input  wire logic                          pad_in,
    output logic                               pad_out,
    output logic                               pad_oe,
    output logic                               gpio_in,
    output logic [ppf_pkg::FN_COUNT-1:0]      fn_in
);

    logic [ppf_pkg::SEL_W-1:0] fn_idx;

    // Peripheral codes start at one, so index the vectors from zero
    assign fn_idx = sel - 3'h1;

    // ----------------------------------------------------------------
    // Outbound steering
    // ----------------------------------------------------------------
    // Registered so the pad never sees a glitch while sel changes
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pad_out <= 1'b0;
            pad_oe  <= 1'b0;
        end else if (ce) begin
            if (sel == ppf_pkg::SEL_GPIO) begin // [RULE15]
                pad_out <= gpio_out;
                pad_oe  <= gpio_oe;
            end else begin // [RULE13]
                pad_out <= fn_out[fn_idx];
                pad_oe  <= fn_oe[fn_idx];
            end
        end
    end

    // ----------------------------------------------------------------
    // Inbound steering
    // ----------------------------------------------------------------
    // General input always sees the pad, whatever function owns it
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            gpio_in <= 1'b0;
            fn_in   <= '0;
        end else if (ce) begin
            gpio_in <= pad_in;
            fn_in   <= '0;
            if (sel != ppf_pkg::SEL_GPIO) begin // [RULE13]
                fn_in[fn_idx] <= pad_in;
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // The release edge still resets the flops, so skip it
    a_gpio_route: assert property ( // [RULE15]
        !sys_rst && ce && sel == ppf_pkg::SEL_GPIO |=>
        pad_out == $past(gpio_out) && pad_oe == $past(gpio_oe))
        else $error("gpio not routed to pad");

    a_fn_route: assert property ( // [RULE13]
        !sys_rst && ce && sel != ppf_pkg::SEL_GPIO |=>
        pad_out == $past(fn_out[fn_idx]) && gpio_in == $past(pad_in))
        else $error("peripheral not routed to pad");

endmodule

`default_nettype wire

// ---- verilog/ppf_pad_ctrl.sv ----
/*
 * Pad pull and function select for the general pins: pull enable,
 * pull polarity and a per-pin function selector behind a register port.
 * Assumes a plain register port whose master never holds a strobe
 * longer than one cycle; all pins synchronous to clk_sys.
 */
// Behaviour
// [RULE1] On-mask bits enable pulls, off-mask bits disable pulls, any direction.
// [RULE2] Every general pin has its pull enabled after reset.
// [RULE3] Pins clear in both masks keep their setting.
// [RULE4] A pin in both on and off masks ends with pull off.
// [RULE5] Pull writes act on peripheral pins, except the crystal pin.
// [RULE6] Up-mask bits select pull-up, down-mask bits select pull-down.
// [RULE7] A pin in both up and down masks gets pull-up.
// [RULE8] Reset polarity is pull-down on pins 3,7,8,12,13,14, else up.
// [RULE9] Polarity read returns stored bitmap, 1 up, 0 down.
// [RULE10] Polarity reaches the pad only while the pull is enabled.
// [RULE11] Software should set polarity before enabling the pull.
// [RULE12] A function selector exists for pins 0 to 15, 17 and 18.
// [RULE13] Each selector connects its pin to exactly one function.
// [RULE14] Software must not program forbidden pin and selector pairs.
// [RULE15] Selector zero is general I/O; one to seven are peripherals.
// [RULE16] Selector read is four bits, bit 3 reserved as zero.
// [RULE17] Bitmap bit n is pin n; bit 16 and 19-31 read zero.
`timescale 1ns/1ps
`default_nettype none

module ppf_pad_ctrl (
    input  wire logic                          clk_sys,
    input  wire logic                          sys_rst,
    input  wire logic                          ce,
    input  wire logic [ppf_pkg::ADDR_W-1:0]   bus_addr,
    input  wire logic [ppf_pkg::DATA_W-1:0]   bus_wdata,
    input  wire logic                          bus_wr,
    input  wire logic                          bus_rd,
    output logic [ppf_pkg::DATA_W-1:0]        bus_rdata,
    output logic [18:0]                        pad_pull_up_en,
    output logic [18:0]                        pad_pull_dn_en,
    input  wire logic [18:0]                   pad_in,
    output logic [18:0]                        pad_out,
    output logic [18:0]                        pad_oe,
    input  wire logic [18:0]                   gpio_out,
    input  wire logic [18:0]                   gpio_oe,
    output logic [18:0]                        gpio_in,
    input  wire logic [132:0]                  fn_out,
    input  wire logic [132:0]                  fn_oe,
    output logic [132:0]                       fn_in
);

    localparam int NP = ppf_pkg::NUM_PIN_SLOTS;
    localparam int NF = ppf_pkg::FN_COUNT;
    localparam int SW = ppf_pkg::SEL_W;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [NP-1:0]        pull_en_r;
    logic [NP-1:0]        pull_pol_r;
    logic [NP-1:0]        on_stage_r;
    logic [NP-1:0]        up_stage_r;
    logic [SW-1:0]        func_sel_r [NP];
    logic [4:0]           func_pin_r;
    logic [NP-1:0]        pull_en_nxt;
    logic [NP-1:0]        pull_pol_nxt;
    logic [31:0]          rdata_nxt;
    logic [NP-1:0]        wr_mask;
    logic [NP-1:0]        lock_mask;
    logic [NP-1:0]        on_eff;
    logic [NP-1:0]        off_eff;
    logic [NP-1:0]        down_eff;
    logic                 xtal_lock;
    logic                 wr_on_stage;
    logic                 wr_pull_commit;
    logic                 wr_up_stage;
    logic                 wr_pol_commit;
    logic                 wr_func;
    logic                 wr_func_pin;
    logic [4:0]           wr_pin;
    logic [SW-1:0]        wr_sel;

    // Pin number decode, shared by the write and read paths
    function automatic logic pin_ok(input logic [4:0] idx);
        pin_ok = 1'b0;
        if (idx < 5'(NP)) begin
            pin_ok = ppf_pkg::PIN_MASK[idx];
        end
    endfunction

    // Widen a pin bitmap to the bus; unused high bits read zero
    function automatic logic [31:0] widen(input logic [NP-1:0] map);
        widen = {{(32 - NP){1'b0}}, map};
    endfunction

    // ----------------------------------------------------------------
    // Write decode
    // ----------------------------------------------------------------
    // A frozen clock enable drops the strobe rather than queueing it
    assign wr_on_stage    = ce && bus_wr
                            && bus_addr == ppf_pkg::REG_PULL_ON_STAGE;
    assign wr_pull_commit = ce && bus_wr
                            && bus_addr == ppf_pkg::REG_PULL_OFF_COMMIT;
    assign wr_up_stage    = ce && bus_wr
                            && bus_addr == ppf_pkg::REG_POL_UP_STAGE;
    assign wr_pol_commit  = ce && bus_wr
                            && bus_addr == ppf_pkg::REG_POL_DN_COMMIT;
    assign wr_func        = ce && bus_wr
                            && bus_addr == ppf_pkg::REG_FUNC_WRITE;
    assign wr_func_pin    = ce && bus_wr
                            && bus_addr == ppf_pkg::REG_FUNC_PIN;

    // Bitmap bits with no pin behind them are dropped
    assign wr_mask = bus_wdata[NP-1:0] & ppf_pkg::PIN_MASK; // [RULE17]
    assign wr_pin  = bus_wdata[ppf_pkg::FW_PIN_LSB +: ppf_pkg::FW_PIN_W];
    assign wr_sel  = bus_wdata[ppf_pkg::FW_SEL_LSB +: SW];

    // ----------------------------------------------------------------
    // Pull enable
    // ----------------------------------------------------------------
    // The crystal pin keeps its pull while it carries the oscillator
    assign xtal_lock = func_sel_r[ppf_pkg::XTAL_PIN] == ppf_pkg::SEL_XTAL;
    assign lock_mask = xtal_lock ? ppf_pkg::XTAL_PIN_MASK : '0; // [RULE5]
    assign on_eff    = on_stage_r & ~lock_mask; // [RULE5]
    assign off_eff   = wr_mask & ~lock_mask; // [RULE5]

    // Off is applied after on, so a pin in both masks ends off
    assign pull_en_nxt = (pull_en_r | on_eff) & ~off_eff; // [RULE1] [RULE4]

    // On-mask is staged; the off-mask write applies both at once
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            on_stage_r <= '0;
        end else if (wr_on_stage) begin
            on_stage_r <= wr_mask;
        end else if (wr_pull_commit) begin
            on_stage_r <= '0;
        end
    end

    // Untouched bits pass through unchanged
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pull_en_r <= ppf_pkg::PULL_EN_RST; // [RULE2]
        end else if (wr_pull_commit) begin
            pull_en_r <= pull_en_nxt; // [RULE3]
        end
    end

    // ----------------------------------------------------------------
    // Pull polarity
    // ----------------------------------------------------------------
    // Down loses to up for a pin named in both masks
    assign down_eff     = wr_mask & ~up_stage_r; // [RULE7]
    assign pull_pol_nxt = (pull_pol_r | up_stage_r) & ~down_eff; // [RULE6]

    // Up-mask staged the same way as the on-mask
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            up_stage_r <= '0;
        end else if (wr_up_stage) begin
            up_stage_r <= wr_mask;
        end else if (wr_pol_commit) begin
            up_stage_r <= '0;
        end
    end

    // Polarity is kept even while the pull is off
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pull_pol_r <= ppf_pkg::PULL_POL_RST; // [RULE8]
        end else if (wr_pol_commit) begin
            pull_pol_r <= pull_pol_nxt; // [RULE3]
        end
    end

    // Pad drive: no pull of either kind unless enabled
    assign pad_pull_up_en = pull_en_r & pull_pol_r; // [RULE10]
    assign pad_pull_dn_en = pull_en_r & ~pull_pol_r; // [RULE10]

    // ----------------------------------------------------------------
    // Function selectors
    // ----------------------------------------------------------------
    // Writes naming a missing pin are ignored; bit 3 is not stored
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NP; i++) begin
                func_sel_r[i] <= ppf_pkg::SEL_RST;
            end
        end else if (wr_func && pin_ok(wr_pin)) begin
            func_sel_r[wr_pin] <= wr_sel; // [RULE12]
        end
    end

    // Pin index used by selector reads
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            func_pin_r <= '0;
        end else if (wr_func_pin) begin
            func_pin_r <= wr_pin;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Unmapped and write-only offsets answer zero
    always_comb begin
        rdata_nxt = '0;
        case (bus_addr)
            ppf_pkg::REG_PULL_ON_STAGE: rdata_nxt = widen(on_stage_r);
            ppf_pkg::REG_PULL_EN:       rdata_nxt = widen(pull_en_r);
            ppf_pkg::REG_POL_UP_STAGE:  rdata_nxt = widen(up_stage_r);
            ppf_pkg::REG_POL:           rdata_nxt = widen(pull_pol_r); // [RULE9]
            ppf_pkg::REG_FUNC_PIN:      rdata_nxt = {27'h0, func_pin_r};
            ppf_pkg::REG_FUNC_READ: begin
                if (pin_ok(func_pin_r)) begin
                    // Bit 3 reserved, reads zero
                    rdata_nxt = {29'h0, func_sel_r[func_pin_r]}; // [RULE16]
                end else begin
                    rdata_nxt = ppf_pkg::RD_BAD_PIN;
                end
            end
            default:                    rdata_nxt = '0;
        endcase
    end

    // Data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            bus_rdata <= '0;
        end else if (ce) begin
            bus_rdata <= bus_rd ? rdata_nxt : '0;
        end
    end

    // ----------------------------------------------------------------
    // Per-pin multiplexers
    // ----------------------------------------------------------------
    // Slot 16 has no pad, so its outputs are tied low
    for (genvar i = 0; i < NP; i++) begin : g_pin
        if (ppf_pkg::PIN_MASK[i]) begin : g_used
            ppf_pin_mux u_mux (
                .clk_sys  (clk_sys),
                .sys_rst  (sys_rst),
                .ce       (ce),
                .sel      (func_sel_r[i]), // [RULE13]
                .gpio_out (gpio_out[i]),
                .gpio_oe  (gpio_oe[i]),
                .fn_out   (fn_out[i*NF +: NF]),
                .fn_oe    (fn_oe[i*NF +: NF]),
                .pad_in   (pad_in[i]),
                .pad_out  (pad_out[i]),
                .pad_oe   (pad_oe[i]),
                .gpio_in  (gpio_in[i]),
                .fn_in    (fn_in[i*NF +: NF])
            );
        end else begin : g_gap
            assign pad_out[i]          = 1'b0;
            assign pad_oe[i]           = 1'b0;
            assign gpio_in[i]          = 1'b0;
            assign fn_in[i*NF +: NF]   = '0;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_pull_reset: assert property ( // [RULE2] [RULE8]
        $fell(sys_rst) |->
        pull_en_r == ppf_pkg::PULL_EN_RST
        && pull_pol_r == ppf_pkg::PULL_POL_RST)
        else $error("wrong pull state after reset");

    a_pull_on_set: assert property ( // [RULE1]
        wr_pull_commit |=>
        (pull_en_r & $past(on_eff)) == $past(on_eff & ~off_eff))
        else $error("pull enable not set");

    a_pull_off_wins: assert property ( // [RULE4]
        wr_pull_commit |=> (pull_en_r & $past(off_eff)) == '0)
        else $error("pull enable not cleared");

    a_pull_keep: assert property ( // [RULE3]
        wr_pull_commit |=>
        ((pull_en_r ^ $past(pull_en_r))
         & ~$past(on_eff | off_eff)) == '0)
        else $error("unnamed pull enable changed");

    a_xtal_lock: assert property ( // [RULE5]
        wr_pull_commit && xtal_lock |=>
        pull_en_r[ppf_pkg::XTAL_PIN]
        == $past(pull_en_r[ppf_pkg::XTAL_PIN]))
        else $error("crystal pin pull changed");

    a_pol_up_wins: assert property ( // [RULE7]
        wr_pol_commit |=>
        (pull_pol_r & $past(up_stage_r)) == $past(up_stage_r))
        else $error("pull-up not selected");

    a_pol_down_set: assert property ( // [RULE6]
        wr_pol_commit |=> (pull_pol_r & $past(down_eff)) == '0
        ##1 $stable(pull_pol_r) || $past(wr_pol_commit))
        else $error("pull-down not selected");

    a_pol_keep: assert property ( // [RULE3]
        wr_pol_commit |=>
        ((pull_pol_r ^ $past(pull_pol_r))
         & ~$past(up_stage_r | wr_mask)) == '0)
        else $error("unnamed polarity changed");

    a_pad_gate: assert property ( // [RULE10]
        ((pad_pull_up_en | pad_pull_dn_en) & ~pull_en_r) == '0
        && (pad_pull_up_en & pad_pull_dn_en) == '0)
        else $error("pull active while disabled");

    a_pol_read: assert property ( // [RULE9]
        ce && bus_rd && bus_addr == ppf_pkg::REG_POL |=>
        bus_rdata == widen($past(pull_pol_r)))
        else $error("polarity read mismatch");

    a_unused_zero: assert property ( // [RULE17]
        ce && bus_rd |=> bus_rdata[31:NP] == '0
        || $past(bus_addr) == ppf_pkg::REG_FUNC_READ)
        else $error("unused bitmap bits set");

    a_sel_read: assert property ( // [RULE16]
        ce && bus_rd && bus_addr == ppf_pkg::REG_FUNC_READ
        && pin_ok(func_pin_r) |=>
        bus_rdata[31:SW] == '0
        && bus_rdata[SW-1:0] == $past(func_sel_r[func_pin_r]))
        else $error("selector read wrong");

    a_func_store: assert property ( // [RULE12]
        wr_func && pin_ok(wr_pin) |=>
        func_sel_r[$past(wr_pin)] == $past(wr_sel))
        else $error("selector not stored");

    c_pull_commit: cover property (wr_pull_commit && on_eff != '0);
    c_pol_commit: cover property (wr_pol_commit && (wr_mask & up_stage_r) != '0);
    c_xtal_lock: cover property (wr_pull_commit && xtal_lock);
    c_func_read: cover property (wr_func ##1 ce && bus_rd
        && bus_addr == ppf_pkg::REG_FUNC_READ);

endmodule

`default_nettype wire

// ---- testbench/ppf_pad_model.sv ----
/*
 * Pad circuit model for the general pins: resolves each pad level from
 * the block's drive, its pull resistors and a floating fallback.
 * Assumes pad signals are synchronous to clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none

module ppf_pad_model (
    input  wire logic        clk_sys,
    input  wire logic [18:0] pad_out,
    input  wire logic [18:0] pad_oe,
    input  wire logic [18:0] pull_up,
    input  wire logic [18:0] pull_dn,
    output logic      [18:0] pad_in
);
    logic [18:0] last_r = 19'h00000;

    // Floating pads show the inverse of their last level, so a stale
    // value never passes for a real one
    always @(posedge clk_sys) begin
        last_r <= pad_in;
    end

    // Drive wins, then pull-up, then pull-down
    always_comb begin
        for (int i = 0; i < 19; i++) begin
            pad_in[i] = pad_oe[i] ? pad_out[i] : pull_up[i] ? 1'b1 :
                        pull_dn[i] ? 1'b0 : ~last_r[i];
        end
    end
endmodule
`default_nettype wire

// ---- testbench/ppf_pad_ctrl_tb.sv ----
/*
 * Self-checking bench for the pin pull and function select block.
 * Assumes ppf_pkg and ppf_pad_model are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none

module ppf_pad_ctrl_tb;
    logic         clk_sys    = 1'b0;
    logic         ce         = 1'b1;
    logic         sys_rst    = 1'b1;
    logic [7:0]   bus_addr   = 8'h00;
    logic [31:0]  bus_wdata  = 32'h0;
    logic         bus_wr     = 1'b0;
    logic         bus_rd     = 1'b0;
    logic [31:0]  bus_rdata;
    logic [18:0]  pu, pd, pad_in, pad_out, pad_oe, gpio_in;
    logic [18:0]  gpio_out   = 19'h0;
    logic [18:0]  gpio_oe    = 19'h7ffff;
    logic [132:0] fn_out     = 133'h0;
    logic [132:0] fn_oe      = ~133'h0;
    logic [132:0] fn_in;
    int           n_errors   = 0;
    int           num_checks = 0;

    always #20 clk_sys = ~clk_sys;

    ppf_pad_ctrl dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .pad_pull_up_en(pu),
        .pad_pull_dn_en(pd), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe(pad_oe), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .gpio_in(gpio_in), .fn_out(fn_out), .fn_oe(fn_oe), .fn_in(fn_in));

    ppf_pad_model pads_i (.clk_sys(clk_sys), .pad_out(pad_out),
        .pad_oe(pad_oe), .pull_up(pu), .pull_dn(pd), .pad_in(pad_in));

    // ----------------------------------------------------------------
    // Bus and check tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus_wr    <= 1'b1;
        bus_addr  <= a;
        bus_wdata <= d;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
        @(posedge clk_sys);
        bus_rd   <= 1'b1;
        bus_addr <= a;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        @(negedge clk_sys);
        chk(nm, e, bus_rdata);
    endtask

    // Stage then commit: the second mask sits four bytes up
    task automatic pair(input logic [7:0] a, input logic [31:0] x,
                        input logic [31:0] y);
        wr(a, x);
        wr(a + 8'h04, y);
    endtask

    // Pad pulls follow enable and polarity; no-pin bit stays low
    task automatic pads(input logic [18:0] en, input logic [18:0] pol);
        @(negedge clk_sys);
        chk("pull up", {13'h0, en & pol & ppf_pkg::PIN_MASK}, {13'h0, pu});
        chk("pull dn", {13'h0, en & ~pol & ppf_pkg::PIN_MASK}, {13'h0, pd});
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        pads(19'h6ffff, 19'h68e77);
        rd(ppf_pkg::REG_PULL_EN, 32'h0006ffff, "pull en");
        rd(ppf_pkg::REG_POL, 32'h00068e77, "polarity");
        pair(ppf_pkg::REG_POL_UP_STAGE, 32'h0, 32'hffffffff);
        pads(19'h6ffff, 19'h0);
        pair(ppf_pkg::REG_POL_UP_STAGE, 32'h3, 32'h1);
        pads(19'h6ffff, 19'h3);
        rd(ppf_pkg::REG_POL, 32'h3, "polarity");
        pair(ppf_pkg::REG_PULL_ON_STAGE, 32'h0, 32'hffffffff);
        pads(19'h0, 19'h3);
        pair(ppf_pkg::REG_PULL_ON_STAGE, 32'h5, 32'h4);
        pads(19'h1, 19'h3);
        pair(ppf_pkg::REG_PULL_ON_STAGE, 32'h2, 32'h0);
        rd(ppf_pkg::REG_PULL_EN, 32'h3, "pull en");
        // Crystal on pin 8 locks its pull enable
        wr(ppf_pkg::REG_FUNC_WRITE, 32'h0708);
        pair(ppf_pkg::REG_PULL_ON_STAGE, 32'h100, 32'h0);
        rd(ppf_pkg::REG_PULL_EN, 32'h3, "pull en xtal");
        wr(ppf_pkg::REG_FUNC_WRITE, 32'h0008);
        pair(ppf_pkg::REG_PULL_ON_STAGE, 32'h100, 32'h0);
        rd(ppf_pkg::REG_PULL_EN, 32'h103, "pull en gpio");
        wr(ppf_pkg::REG_FUNC_PIN, 32'h10);
        rd(ppf_pkg::REG_FUNC_READ, 32'hffffffff, "no pin sel");
        // Pin 11 has a function for every selector value
        for (int k = 0; k < 8; k++) begin
            wr(ppf_pkg::REG_FUNC_WRITE, 32'h0b | (32'(k) << 8));
            gpio_out <= (k == 0) ? 19'h00800 : 19'h0;
            fn_out   <= (k == 0) ? 133'h0 : (133'h1 << (76 + k));
            repeat (3) @(posedge clk_sys);
            pads(19'h103, 19'h3);
            chk("pad out", 32'h1, {31'h0, pad_out[11]});
            chk("pad oe", 32'h1, {31'h0, pad_oe[11]});
            chk("gpio in", 32'h1, {31'h0, gpio_in[11]});
            chk("fn in", 32'(fn_out[77+:7]), 32'(fn_in[77+:7]));
            wr(ppf_pkg::REG_FUNC_PIN, 32'h0b);
            rd(ppf_pkg::REG_FUNC_READ, 32'(k), "selector");
        end
        pair(ppf_pkg::REG_PULL_ON_STAGE, 32'h800, 32'h0);
        rd(ppf_pkg::REG_PULL_EN, 32'h903, "pull en periph");
        // Off-mask is ignored too while pin 8 carries the crystal
        wr(ppf_pkg::REG_FUNC_WRITE, 32'h0708);
        pair(ppf_pkg::REG_PULL_ON_STAGE, 32'h0, 32'h100);
        rd(ppf_pkg::REG_PULL_EN, 32'h903, "pull en xtal off");
        // A frozen clock enable loses the whole pull write
        ce <= 1'b0;
        pair(ppf_pkg::REG_PULL_ON_STAGE, 32'h0, 32'h800);
        ce <= 1'b1;
        rd(ppf_pkg::REG_PULL_EN, 32'h903, "pull en frozen");
        // Reset in mid-run restores pulls and selectors
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        pads(19'h6ffff, 19'h68e77);
        wr(ppf_pkg::REG_FUNC_PIN, 32'h08);
        rd(ppf_pkg::REG_FUNC_READ, 32'h0, "sel after reset");
        final_report();
    end

    // Whole run is under two hundred cycles; cut a hang short
    initial begin
        #(5000 * 40);
        n_errors++;
        final_report();
    end
endmodule
`default_nettype wire
